// ==== oversampling_average_filter.sv ====
// Oversampling averaging filter with APB register access

module oversampling_average_filter #(
    parameter int CHANNELS    = oversampling_pkg::CHANNELS,
    parameter int SLOT_CYCLES = oversampling_pkg::SLOT_CYCLES
) (
    input  wire logic                                        ref_clk,
    input  wire logic                                        rstn,
    input  wire logic [oversampling_pkg::ADDR_W-1:0]         paddr,
    input  wire logic                                        psel,
    input  wire logic                                        penable,
    input  wire logic                                        pwrite,
    input  wire logic [31:0]                                 pwdata,
    output logic      [31:0]                                 prdata,
    output logic                                             pready,
    output logic                                             pslverr,
    input  wire logic                                        convert_start_group_a,
    input  wire logic                                        convert_start_group_b,
    input  wire logic                                        core_done,
    input  wire logic [CHANNELS*oversampling_pkg::RESULT_W-1:0] core_data,
    output logic                                             core_convert,
    output logic                                             conversion_busy,
    output logic                                             bandgap_enable,
    output logic                                             reference_io_oe,
    output logic                                             ref_buffer_enable,
    output logic                                             range_10v
);
    localparam int RW  = oversampling_pkg::RESULT_W;
    localparam int CW  = oversampling_pkg::COUNT_W;
    localparam int GAP_LIMIT = SLOT_CYCLES - 1;

    // Gap counter is eight bits and saturates
    if (CHANNELS < 1 || CHANNELS > 8 || SLOT_CYCLES < 2 || SLOT_CYCLES > 256) begin : g_check
        $error("oversampling_average_filter parameters out of range");
    end

    // Wide span is twice the narrow one, and so is its code step
    if (oversampling_pkg::LSB_WIDE_UV_E4 != 2 * oversampling_pkg::LSB_NARROW_UV_E4) begin : g_lsb_check
        $error("code step constants disagree");
    end

    typedef struct packed {
        logic [1:0]                  sync_a;
        logic [1:0]                  sync_b;
        logic                        start_prev;
        oversampling_pkg::phase_type phase;
        logic [CW-1:0]               samples;
        logic [2:0]                  shift;
        logic [31:0]                 ctrl;
        logic                        busy;
        logic                        invalid;
        logic                        done;
        logic                        convert;
        logic                        pready;
        logic                        pslverr;
        logic [31:0]                 prdata;
        logic                        bandgap;
        logic                        ref_oe;
        logic                        buffer_en;
        logic                        range;
        logic [7:0]                  gap;
    } filter_state_type;

    localparam filter_state_type RESET_STATE = '{
        phase:     oversampling_pkg::ST_IDLE,
        ctrl:      oversampling_pkg::CTRL_RESET,
        bandgap:   1'b1,
        ref_oe:    1'b1,
        buffer_en: 1'b1,
        default:   '0
    };

    filter_state_type              st_q;
    filter_state_type              st_d;
    logic [CHANNELS-1:0][RW-1:0]   results;
    logic                          slot_open;
    logic                          start_level;
    logic                          start_rise;
    logic                          take_sample;
    logic                          last_sample;
    logic                          begin_seq;
    logic [2:0]                    ratio;
    logic [2:0]                    ratio_shift;
    logic [CW-1:0]                 target;
    logic                          access;
    logic                          is_result;
    logic [11:0]                   result_off;
    logic [2:0]                    result_idx;

    // Both groups come from one host signal while averaging
    assign start_level = st_q.sync_a[1] & st_q.sync_b[1];
    assign start_rise  = start_level & ~st_q.start_prev;

    assign ratio       = st_q.ctrl[oversampling_pkg::CTRL_RATIO_LSB +: 3];
    // Invalid pattern falls back to single samples rather than hanging
    assign ratio_shift = (ratio == oversampling_pkg::RATIO_INVALID) ? oversampling_pkg::RATIO_NONE : ratio;
    assign target      = CW'(1) << st_q.shift;
    assign last_sample = (st_q.samples == target - 1'b1);

    assign begin_seq   = (st_q.phase == oversampling_pkg::ST_IDLE) && start_rise;
    assign take_sample = (st_q.phase == oversampling_pkg::ST_CONVERT) && core_done;

    assign access     = psel & penable & ~st_q.pready;
    assign result_off = paddr - oversampling_pkg::RESULT_BASE;
    assign result_idx = result_off[4:2];
    assign is_result  = (paddr >= oversampling_pkg::RESULT_BASE) && (paddr < oversampling_pkg::RESULT_END)
                        && (32'(result_idx) < CHANNELS);

    genvar ch;
    for (ch = 0; ch < CHANNELS; ch++) begin : g_chan
        channel_average #(
            .RESULT_W  (RW),
            .MAX_SHIFT (oversampling_pkg::MAX_SHIFT)
        ) u_chan (
            .ref_clk  (ref_clk),
            .rstn     (rstn),
            .clear    (begin_seq),
            .add      (take_sample),
            .last     (last_sample),
            .shift    (st_q.shift),
            .sample   (core_data[ch*RW +: RW]),
            .result_q (results[ch])
        );
    end

    slot_timer #(
        .SLOT_CYCLES (SLOT_CYCLES)
    ) u_slot (
        .ref_clk     (ref_clk),
        .rstn        (rstn),
        .restart     (st_d.convert),
        .slot_open_q (slot_open)
    );

    always_comb begin
        st_d            = st_q;
        st_d.sync_a     = {st_q.sync_a[0], convert_start_group_a};
        st_d.sync_b     = {st_q.sync_b[0], convert_start_group_b};
        st_d.start_prev = start_level;
        st_d.convert    = 1'b0;
        st_d.pready     = 1'b0;
        st_d.pslverr    = 1'b0;
        st_d.gap        = st_q.convert ? 8'h00 : (&st_q.gap ? st_q.gap : st_q.gap + 8'h01);

        unique case (st_q.phase)
            oversampling_pkg::ST_IDLE: begin
                if (start_rise) begin
                    st_d.shift   = ratio_shift;
                    st_d.invalid = (ratio == oversampling_pkg::RATIO_INVALID);
                    st_d.samples = '0;
                    st_d.busy    = 1'b1;
                    st_d.convert = 1'b1;
                    st_d.phase   = oversampling_pkg::ST_CONVERT;
                end
            end
            oversampling_pkg::ST_CONVERT: begin
                if (core_done) begin
                    if (last_sample) begin
                        // Results land on the same edge busy falls
                        st_d.busy  = 1'b0;
                        st_d.done  = 1'b1;
                        st_d.phase = oversampling_pkg::ST_IDLE;
                    end else begin
                        st_d.samples = st_q.samples + 1'b1;
                        st_d.phase   = oversampling_pkg::ST_SLOT;
                    end
                end
            end
            oversampling_pkg::ST_SLOT: begin
                // One slot per sample caps throughput at the base rate over the count
                if (slot_open) begin
                    st_d.convert = 1'b1;
                    st_d.phase   = oversampling_pkg::ST_CONVERT;
                end
            end
            default: begin
                st_d.phase = oversampling_pkg::ST_IDLE;
                st_d.busy  = 1'b0;
            end
        endcase

        if (access) begin
            st_d.pready = 1'b1;
            st_d.prdata = '0;
            if (paddr == oversampling_pkg::CTRL_OFFSET) begin
                st_d.prdata = st_q.ctrl;
            end else if (paddr == oversampling_pkg::STATUS_OFFSET) begin
                st_d.prdata[oversampling_pkg::STATUS_BUSY_BIT]    = st_q.busy;
                st_d.prdata[oversampling_pkg::STATUS_INVALID_BIT] = st_q.invalid;
                st_d.prdata[oversampling_pkg::STATUS_DONE_BIT]    = st_q.done;
                // A completion in this very cycle keeps the flag set
                if (!pwrite && !(take_sample && last_sample)) begin
                    st_d.done = 1'b0;
                end
            end else if (is_result) begin
                st_d.prdata[RW-1:0] = results[result_idx];
            end else begin
                st_d.pslverr = 1'b1;
            end
        end

        if (psel && penable && st_q.pready && pwrite && paddr == oversampling_pkg::CTRL_OFFSET) begin
            st_d.ctrl = pwdata & oversampling_pkg::CTRL_MASK;
        end

        st_d.bandgap   = st_q.ctrl[oversampling_pkg::CTRL_REFERENCE_SOURCE_SELECT_BIT];
        st_d.ref_oe    = st_q.ctrl[oversampling_pkg::CTRL_REFERENCE_SOURCE_SELECT_BIT];
        st_d.buffer_en = 1'b1;
        st_d.range     = st_q.ctrl[oversampling_pkg::CTRL_RANGE_BIT];
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            st_q <= RESET_STATE;
        end else begin
            st_q <= st_d;
        end
    end

    assign prdata            = st_q.prdata;
    assign pready            = st_q.pready;
    assign pslverr           = st_q.pslverr;
    assign core_convert      = st_q.convert;
    assign conversion_busy   = st_q.busy;
    assign bandgap_enable    = st_q.bandgap;
    assign reference_io_oe   = st_q.ref_oe;
    assign ref_buffer_enable = st_q.buffer_en;
    assign range_10v         = st_q.range;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);

    sequence s_seq_start;
        begin_seq;
    endsequence

    sequence s_seq_end;
        take_sample && last_sample;
    endsequence

    sequence s_apb_access;
        psel && penable && !pready;
    endsequence

    property conv_internal_p;
        $past(st_q.phase) == oversampling_pkg::ST_SLOT && core_convert |-> 32'(st_q.gap) >= GAP_LIMIT;
    endproperty

    a_ratio_decode_ok: assert property (s_seq_start |=> st_q.shift == (($past(ratio) == 3'h7) ? 3'h0 : $past(ratio)))
        else $error("ratio decoded wrongly");
    a_slot_spacing_min: assert property (conv_internal_p)
        else $error("internal strobe closer than one slot");
    a_first_edge_start: assert property (s_seq_start |=> core_convert && conversion_busy)
        else $error("host edge did not start a conversion");
    a_internal_strobe: assert property (st_q.phase == oversampling_pkg::ST_SLOT && slot_open |=> core_convert)
        else $error("internal strobe missing");
    a_busy_hold_seq: assert property (conversion_busy && !take_sample |=> conversion_busy)
        else $error("busy dropped mid sequence");
    a_busy_release: assert property (s_seq_end |=> !conversion_busy && st_q.done)
        else $error("busy not released at end");
    a_ref_mode_follow: assert property (##1 reference_io_oe == $past(st_q.ctrl[4]) && bandgap_enable == reference_io_oe)
        else $error("reference mode not followed");
    a_buffer_always_on: assert property (##1 ref_buffer_enable)
        else $error("reference buffer disabled");
    a_range_follow: assert property (##1 range_10v == $past(st_q.ctrl[3]))
        else $error("range output not following control");
    a_invalid_latched: assert property (s_seq_start
        |=> st_q.invalid == ($past(ratio) == oversampling_pkg::RATIO_INVALID))
        else $error("invalid ratio not flagged");
    a_start_sets_busy: assert property ($rose(conversion_busy) |-> core_convert)
        else $error("busy rose without a conversion request");
    a_idle_no_strobe: assert property (st_q.phase == oversampling_pkg::ST_IDLE && !start_rise
        |=> !core_convert)
        else $error("conversion request without a start");
    a_convert_pulse: assert property (core_convert |=> !core_convert)
        else $error("conversion request longer than one cycle");
    a_results_held: assert property (!(take_sample && last_sample) |=> $stable(results))
        else $error("results changed mid sequence");
    a_seq_end_idle: assert property (s_seq_end |=> st_q.phase == oversampling_pkg::ST_IDLE)
        else $error("sequencer not idle after last sample");
    // Bus handshake: one answer per access, one cycle wide
    a_apb_answer: assert property (s_apb_access |=> pready)
        else $error("access not answered next cycle");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("ready held longer than one cycle");
    a_slverr_with_ready: assert property (pslverr |-> pready)
        else $error("error flag without ready");
    a_ctrl_write_only: assert property (!(psel && penable && pready && pwrite) |=> $stable(st_q.ctrl))
        else $error("control changed without a write");
endmodule // oversampling_average_filter

// ==== oversampling_pkg.sv ====
// Shared constants and types of the oversampling averaging filter
package oversampling_pkg;

    // Result coding
    localparam int RESULT_W  = 18;
    localparam int CHANNELS  = 8;
    localparam int RATIO_W   = 3;
    localparam int MAX_SHIFT = 6;
    localparam int ACC_W     = RESULT_W + MAX_SHIFT;
    localparam int COUNT_W   = MAX_SHIFT + 1;
    localparam logic [RATIO_W-1:0] RATIO_NONE    = 3'h0;
    localparam logic [RATIO_W-1:0] RATIO_INVALID = 3'h7;

    // Code step = span / 2**18, in units of 0.0001 uV
    localparam int LSB_WIDE_UV_E4   = 762950;
    localparam int LSB_NARROW_UV_E4 = 381475;

    // Sample slot timing: 500 kSPS per channel without averaging
    localparam int CLK_PERIOD_NS    = 100;
    localparam int SAMPLE_PERIOD_NS = 2000;
    localparam int SLOT_CYCLES      = (SAMPLE_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Register map (byte addresses)
    localparam int          ADDR_W        = 12;
    localparam logic [11:0] CTRL_OFFSET   = 12'h000;
    localparam logic [11:0] STATUS_OFFSET = 12'h004;
    localparam logic [11:0] RESULT_BASE   = 12'h020;
    localparam logic [11:0] RESULT_END    = 12'h040;

    // Control fields
    localparam int          CTRL_RATIO_LSB  = 0;
    localparam int          CTRL_RANGE_BIT  = 3;
    localparam int          CTRL_REFERENCE_SOURCE_SELECT_BIT = 4;
    localparam logic [31:0] CTRL_MASK       = 32'h0000_001f;
    localparam logic [31:0] CTRL_RESET      = 32'h0000_0010;

    // Status fields
    localparam int STATUS_BUSY_BIT    = 0;
    localparam int STATUS_INVALID_BIT = 1;
    localparam int STATUS_DONE_BIT    = 2;

    typedef enum logic [2:0] {
        ST_IDLE    = 3'b001,
        ST_CONVERT = 3'b010,
        ST_SLOT    = 3'b100
    } phase_type;

endpackage

// ==== slot_timer.sv ====
// Internal sampling slot timer
module slot_timer #(
    parameter int SLOT_CYCLES = oversampling_pkg::SLOT_CYCLES
) (
    input  wire logic ref_clk,
    input  wire logic rstn,
    input  wire logic restart,
    output logic      slot_open_q
);
    localparam int CNT_W = $clog2(SLOT_CYCLES + 1);
    localparam logic [CNT_W-1:0] LAST = CNT_W'(SLOT_CYCLES - 1);
    localparam logic [CNT_W-1:0] OPEN = CNT_W'(SLOT_CYCLES - 2);

    if (SLOT_CYCLES < 2) begin : g_check
        $error("slot_timer needs at least two cycles per slot");
    end

    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic             open;
    } timer_state_type;

    timer_state_type st_q;
    timer_state_type st_d;

    always_comb begin
        st_d = st_q;
        if (restart) begin
            st_d.cnt  = '0;
            st_d.open = 1'b0;
        end else begin
            if (st_q.cnt != LAST) begin
                st_d.cnt = st_q.cnt + 1'b1;
            end
            // Opens so that the next strobe lands one full slot after restart
            st_d.open = (st_q.cnt >= OPEN);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign slot_open_q = st_q.open;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);

    a_timer_restart_closed: assert property (restart |=> !slot_open_q [*2])
        else $error("slot opened right after restart");
endmodule // slot_timer

// ==== channel_average.sv ====
// Per-channel accumulator and decimator
module channel_average #(
    parameter int RESULT_W  = oversampling_pkg::RESULT_W,
    parameter int MAX_SHIFT = oversampling_pkg::MAX_SHIFT
) (
    input  wire logic                 ref_clk,
    input  wire logic                 rstn,
    input  wire logic                 clear,
    input  wire logic                 add,
    input  wire logic                 last,
    input  wire logic [2:0]           shift,
    input  wire logic [RESULT_W-1:0]  sample,
    output logic      [RESULT_W-1:0]  result_q
);
    localparam int ACC_W = RESULT_W + MAX_SHIFT;

    if (MAX_SHIFT > 7 || RESULT_W < 2) begin : g_check
        $error("channel_average parameters out of range");
    end

    typedef struct packed {
        logic signed [ACC_W-1:0]    acc;
        logic        [RESULT_W-1:0] result;
    } chan_state_type;

    chan_state_type          st_q;
    chan_state_type          st_d;
    logic signed [ACC_W-1:0] sum;
    logic signed [ACC_W-1:0] mean;

    // Two's complement sample, sign extended into the accumulator
    assign sum  = st_q.acc + ACC_W'(signed'(sample));
    assign mean = sum >>> shift;

    always_comb begin
        st_d = st_q;
        if (clear) begin
            st_d.acc = '0;
        end else if (add) begin
            if (last) begin
                // Truncating divide keeps one 18-bit word per channel
                st_d.result = mean[RESULT_W-1:0];
                st_d.acc    = '0;
            end else begin
                st_d.acc = sum;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign result_q = st_q.result;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);

    a_single_sample_pass: assert property (add && last && !clear && shift == 3'h0 && st_q.acc == '0
        |=> result_q == $past(sample))
        else $error("single sample not passed through");
    a_result_sign_kept: assert property (add && last && !clear |=> result_q[RESULT_W-1] == $past(sum[ACC_W-1]))
        else $error("result sign differs from accumulated sign");
endmodule // channel_average

// ==== core_model.sv ====
// Behavioural converter core that answers each conversion request of the filter
module core_model (
    input  wire logic                                                       ref_clk,
    input  wire logic                                                       rstn,
    input  wire logic                                                       core_convert,
    input  wire logic                                                       clear_count,
    input  wire logic                                                       slow,
    output logic                                                            core_done,
    output logic [oversampling_pkg::CHANNELS*oversampling_pkg::RESULT_W-1:0] core_data
);
    timeunit 1ns;
    timeprecision 1ns;

    logic       pending;
    logic [5:0] wait_cnt;
    int         k;

    always @(posedge ref_clk) begin
        core_done <= 1'b0;
        // Data is only valid with the done pulse, so it toggles otherwise
        core_data <= ~core_data;
        if (!rstn) begin
            pending   <= 1'b0;
            k         <= 0;
            core_data <= '0;
        end else begin
            if (clear_count) begin
                k <= 0;
            end
            if (core_convert) begin
                pending  <= 1'b1;
                // Slow answer is longer than one sample slot
                wait_cnt <= slow ? 6'h19 : 6'h03;
            end else if (pending && wait_cnt != 6'h00) begin
                wait_cnt <= wait_cnt - 6'h01;
            end else if (pending) begin
                pending   <= 1'b0;
                core_done <= 1'b1;
                k         <= k + 1;
                for (int n = 0; n < oversampling_pkg::CHANNELS; n++) begin
                    core_data[n*18 +: 18] <= 18'(n * 4099 - 16000 + k * 13 - (k % 3) * 40);
                end
            end
        end
    end
endmodule // core_model

// ==== oversampling_average_filter_tb.sv ====
// Self-checking testbench of the oversampling averaging filter
module oversampling_average_filter_tb;
    timeunit 1ns;
    timeprecision 1ns;

    typedef struct packed {
        logic [2:0] ratio;
        logic       range;
        logic       reference_source_select;
        logic       slow;
        logic [6:0] count;
    } row_type;

    localparam int SLOT = oversampling_pkg::SLOT_CYCLES;

    logic          ref_clk = 1'b0;
    logic          rstn, psel, penable, pwrite, pready, pslverr, start_pin;
    logic [11:0]   paddr;
    logic [31:0]   pwdata, prdata, rd;
    logic          core_done, core_convert, conversion_busy, clear_count, slow, err, busy_prev = 1'b0;
    logic          bandgap_enable, reference_io_oe, ref_buffer_enable, range_10v;
    logic [143:0]  core_data;
    int            failures = 0, compares = 0, cyc = 0, conv_total = 0, done_total = 0, gap_err = 0, last_conv = 0;
    row_type       rows [8] = '{'{3'h0, 1'b0, 1'b1, 1'b0, 7'h01}, '{3'h1, 1'b1, 1'b0, 1'b1, 7'h02},
                                '{3'h2, 1'b0, 1'b0, 1'b0, 7'h04}, '{3'h3, 1'b1, 1'b1, 1'b1, 7'h08},
                                '{3'h4, 1'b0, 1'b1, 1'b0, 7'h10}, '{3'h5, 1'b1, 1'b0, 1'b0, 7'h20},
                                '{3'h6, 1'b0, 1'b1, 1'b0, 7'h40}, '{3'h7, 1'b1, 1'b1, 1'b0, 7'h01}};

    oversampling_average_filter #(.SLOT_CYCLES(SLOT)) uut (
        .ref_clk(ref_clk), .rstn(rstn), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .convert_start_group_a(start_pin),
        .convert_start_group_b(start_pin),
        .core_done(core_done), .core_data(core_data), .core_convert(core_convert),
        .conversion_busy(conversion_busy), .bandgap_enable(bandgap_enable), .reference_io_oe(reference_io_oe),
        .ref_buffer_enable(ref_buffer_enable), .range_10v(range_10v));

    core_model core (.ref_clk(ref_clk), .rstn(rstn), .core_convert(core_convert), .clear_count(clear_count),
                     .slow(slow), .core_done(core_done), .core_data(core_data));

    always #50 ref_clk = ~ref_clk;

    always @(posedge ref_clk) begin
        cyc       <= cyc + 1;
        busy_prev <= conversion_busy;
        if (core_done === 1'b1) done_total <= done_total + 1;
        if (core_convert === 1'b1) begin
            conv_total <= conv_total + 1;
            last_conv  <= cyc;
            if (busy_prev === 1'b1 && cyc - last_conv < SLOT) gap_err <= gap_err + 1;
        end
    end

    task summarize;
        if (failures == 0 && compares > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    task check(input logic [31:0] got, input logic [31:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int i;
        @(posedge ref_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge ref_clk);
            if (pready === 1'b1) break;
        end
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (i == 20) begin
            failures++;
            $display("unexpected at %0t: bus wait ran out", $time);
            summarize();
        end
    endtask

    task wait_busy(input logic lvl, input int lim);
        int i;
        for (i = 0; i < lim && conversion_busy !== lvl; i++) @(posedge ref_clk);
        if (i == lim) begin
            failures++;
            $display("unexpected at %0t: busy wait ran out", $time);
            summarize();
        end
    endtask

    task run_seq(input int n_exp);
        int bc, bd;
        bc = conv_total;
        bd = done_total;
        clear_count <= 1'b1;
        @(posedge ref_clk);
        clear_count <= 1'b0;
        start_pin   <= 1'b1;
        wait_busy(1'b1, 10);
        wait_busy(1'b0, n_exp * 40 + 100);
        @(posedge ref_clk);
        check(done_total - bd, n_exp, "core samples");
        check(conv_total - bc, n_exp, "sample requests");
        start_pin <= 1'b0;
    endtask

    initial begin
        int sh, sum, ev, bc;
        {rstn, psel, penable, pwrite, paddr, pwdata, start_pin, clear_count, slow} = '0;
        repeat (3) @(posedge ref_clk);
        rstn <= 1'b1;
        repeat (4) @(posedge ref_clk);
        foreach (rows[r]) begin
            apb(1'b1, oversampling_pkg::CTRL_OFFSET, {27'h000_0000, rows[r].reference_source_select, rows[r].range, rows[r].ratio});
            slow <= rows[r].slow;
            repeat (2) @(posedge ref_clk);
            check(range_10v, rows[r].range, "range");
            check(bandgap_enable, rows[r].reference_source_select, "bandgap");
            check(reference_io_oe, rows[r].reference_source_select, "reference pin");
            check(ref_buffer_enable, 1'b1, "buffer");
            sh = $clog2(rows[r].count);
            run_seq(rows[r].count);
            for (int n = 0; n < 8; n++) begin
                sum = 0;
                for (int k = 0; k < rows[r].count; k++) sum += n * 4099 - 16000 + k * 13 - (k % 3) * 40;
                ev = sum >>> sh;
                apb(1'b0, oversampling_pkg::RESULT_BASE + 12'(4 * n), 32'h0000_0000);
                check(rd, {14'h0000, ev[17:0]}, "channel result");
            end
            apb(1'b0, oversampling_pkg::STATUS_OFFSET, 32'h0000_0000);
            check(rd, {29'h0000_0000, 1'b1, rows[r].ratio == 3'h7, 1'b0}, "status");
        end
        check(gap_err, 0, "sample slot spacing");
        // Second start edge in mid-sequence must not add samples
        apb(1'b1, oversampling_pkg::CTRL_OFFSET, 32'h0000_001a);
        bc = conv_total;
        start_pin <= 1'b1;
        wait_busy(1'b1, 10);
        repeat (2) @(posedge ref_clk);
        start_pin <= 1'b0;
        repeat (4) @(posedge ref_clk);
        start_pin <= 1'b1;
        wait_busy(1'b0, 300);
        start_pin <= 1'b0;
        repeat (10) @(posedge ref_clk);
        check(conv_total - bc, 4, "start while busy");
        check(conversion_busy, 1'b0, "late start");
        apb(1'b0, 12'h010, 32'h0000_0000);
        check({err, rd[30:0]}, 32'h8000_0000, "unmapped read");
        rstn <= 1'b0;
        repeat (3) @(posedge ref_clk);
        check({bandgap_enable, reference_io_oe, ref_buffer_enable, range_10v, conversion_busy}, 5'h1c, "reset pins");
        rstn <= 1'b1;
        apb(1'b0, oversampling_pkg::CTRL_OFFSET, 32'h0000_0000);
        check(rd, oversampling_pkg::CTRL_RESET, "control after reset");
        summarize();
    end
endmodule // oversampling_average_filter_tb
